//--- rtl/high_carrier_select.sv
// High-carrier source selector with optional inversion and falling-edge
// synchronisation of the switch to the low carrier, behind an AHB-Lite slave.
// Assumes the PWM units, reference clock and modulation data run on hclk,
// and the two carrier pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none

module high_carrier_select
  import carrier_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mod_data,
  input wire logic capture_pwm_unit_one,
  input wire logic capture_pwm_unit_two,
  input wire logic capture_pwm_unit_three,
  input wire logic capture_pwm_unit_four,
  input wire logic reference_clock_output,
  input wire logic carrier_input_pin_one,
  input wire logic carrier_input_pin_two,
  output logic high_carrier,
  output logic high_carrier_active
);

  sel_state_s state_q;
  sel_state_s state_d;
  logic picked;
  logic fall;
  logic addr_phase;
  logic [3:0] wr_sel;

  pin_sync_if pins_if ();

  // Pins are gathered into the bundle and synchronised before any use.
  assign pins_if.raw = {carrier_input_pin_two, carrier_input_pin_one};

  pin_sync u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins(pins_if.sync_side)
  );

  // Source multiplexer; reserved codes fall through to a constant low.
  function automatic logic pick_source(
    input logic [3:0] sel,
    input logic [1:0] pin,
    input logic refclk,
    input logic [3:0] pwm
  );
    logic result;
    result = 1'b0;
    case (sel)
      SEL_GROUND: result = 1'b0;
      SEL_PIN_ONE: result = pin[0];
      SEL_PIN_TWO: result = pin[1];
      SEL_REF_CLK: result = refclk;
      SEL_PWM_ONE: result = pwm[0];
      SEL_PWM_TWO: result = pwm[1];
      SEL_PWM_THREE: result = pwm[2];
      SEL_PWM_FOUR: result = pwm[3];
      default: result = 1'b0;
    endcase
    return result;
  endfunction

  // The PWM outputs are only meaningful while those units are in PWM mode;
  // this block forwards whatever level they present.
  assign picked = pick_source(
    state_q.ctrl.sel,
    pins_if.synced,
    reference_clock_output,
    {capture_pwm_unit_four, capture_pwm_unit_three,
     capture_pwm_unit_two, capture_pwm_unit_one}
  );

  // Edge and bus qualifiers.
  assign fall = state_q.carrier_prev & ~state_q.carrier;
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_sel = hwdata[CTRL_SEL_LSB +: CTRL_SEL_W];

  // Next-state logic: register writes first, so a read that follows a
  // write back to back already sees the new control value.
  always_comb
  begin
    state_d = state_q;
    state_d.wr_ctrl = 1'b0;
    state_d.rd_ctrl = 1'b0;
    if (state_q.wr_ctrl)
    begin
      state_d.ctrl.sel = wr_sel;
      state_d.ctrl.sync_en = hwdata[CTRL_SYNC_BIT];
      state_d.ctrl.invert = hwdata[CTRL_INV_BIT];
    end
    if (addr_phase)
    begin
      state_d.wr_ctrl = hwrite && (haddr == CTRL_OFFSET);
      state_d.rd_ctrl = !hwrite && (haddr == CTRL_OFFSET);
      state_d.rdata = 32'h0000_0000;
      if (!hwrite && haddr == CTRL_OFFSET)
      begin
        // Bit 4 is never loaded, so it always reads back as zero.
        state_d.rdata[CTRL_SEL_LSB +: CTRL_SEL_W] = state_d.ctrl.sel;
        state_d.rdata[CTRL_SYNC_BIT] = state_d.ctrl.sync_en;
        state_d.rdata[CTRL_INV_BIT] = state_d.ctrl.invert;
      end
      else if (!hwrite && haddr == STATUS_OFFSET)
      begin
        state_d.rdata[STAT_CARRIER_BIT] = state_q.carrier;
        state_d.rdata[STAT_HIGH_BIT] = state_q.phase != phase_low;
        state_d.rdata[STAT_WAIT_BIT] = state_q.phase == phase_wait_fall;
      end
    end
    // Selected source, inverted on request, is retimed into one flop.
    state_d.carrier = picked ^ state_q.ctrl.invert;
    state_d.carrier_prev = state_q.carrier;
    // Modulator phase: the switch to the low carrier may be deferred.
    unique case (state_q.phase)
      phase_low:
      begin
        if (mod_data)
          state_d.phase = phase_high;
      end
      phase_high:
      begin
        if (!mod_data)
        begin
          if (state_q.ctrl.sync_en && !fall)
            state_d.phase = phase_wait_fall;
          else
            state_d.phase = phase_low;
        end
      end
      phase_wait_fall:
      begin
        // Clearing the sync enable while waiting releases at once.
        if (mod_data)
          state_d.phase = phase_high;
        else if (!state_q.ctrl.sync_en || fall)
          state_d.phase = phase_low;
      end
    endcase
  end

  // Single register for all state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= SEL_STATE_RESET;
    else
      state_q <= state_d;
  end

  // Zero-wait slave: every transfer completes OKAY in its data phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_q.rdata;
  assign high_carrier = state_q.carrier;
  assign high_carrier_active = state_q.phase != phase_low;

  // Checks on the selector, phase control and register file.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Routing: codes three to seven forward their source, inverted on request, one edge later.
  property p_route(logic [3:0] code, logic src);
    state_q.ctrl.sel == code |=>
      state_q.carrier == ($past(src) ^ $past(state_q.ctrl.invert));
  endproperty

  a_sync_hold: assert property (
    (state_q.phase != phase_low && state_q.ctrl.sync_en && !mod_data && !fall)
      |=> state_q.phase == phase_wait_fall)
    else $error("high carrier left before a falling edge");

  a_async_drop: assert property (
    (state_q.phase != phase_low && !state_q.ctrl.sync_en && !mod_data)
      |=> state_q.phase == phase_low)
    else $error("high carrier not left at once without sync");

  a_bit4_zero: assert property (
    state_q.rd_ctrl |-> (hrdata[CTRL_RSVD_BIT] == 1'b0 &&
      hrdata[CTRL_SEL_LSB +: CTRL_SEL_W] == state_q.ctrl.sel))
    else $error("control read back wrong");

  a_sel_write: assert property (
    state_q.wr_ctrl |=> state_q.ctrl.sel == $past(wr_sel))
    else $error("selector not loaded from write data");

  a_reserved_none: assert property (
    state_q.ctrl.sel[3] |=> state_q.carrier == $past(state_q.ctrl.invert))
    else $error("reserved code connected a source");

  a_route_pwm4: assert property (p_route(SEL_PWM_FOUR, capture_pwm_unit_four))
    else $error("code seven misrouted");

  a_route_pwm3: assert property (p_route(SEL_PWM_THREE, capture_pwm_unit_three))
    else $error("code six misrouted");

  a_route_pwm2: assert property (p_route(SEL_PWM_TWO, capture_pwm_unit_two))
    else $error("code five misrouted");

  a_route_pwm1: assert property (p_route(SEL_PWM_ONE, capture_pwm_unit_one))
    else $error("code four misrouted");

  a_route_refclk: assert property (p_route(SEL_REF_CLK, reference_clock_output))
    else $error("code three misrouted");

  a_route_pin2: assert property (
    state_q.ctrl.sel == SEL_PIN_TWO ##0 $stable(state_q.ctrl) [*3] |->
      state_q.carrier == ($past(carrier_input_pin_two, 3) ^ state_q.ctrl.invert))
    else $error("code two misrouted");

  a_route_pin1: assert property (
    state_q.ctrl.sel == SEL_PIN_ONE ##0 $stable(state_q.ctrl) [*3] |->
      state_q.carrier == ($past(carrier_input_pin_one, 3) ^ state_q.ctrl.invert))
    else $error("code one misrouted");

  a_ground_low: assert property (
    state_q.ctrl.sel == SEL_GROUND |=>
      state_q.carrier == $past(state_q.ctrl.invert))
    else $error("ground code not low");

  a_no_invert: assert property (
    !state_q.ctrl.invert |=> state_q.carrier == $past(picked))
    else $error("carrier inverted with polarity zero");

  a_invert: assert property (
    state_q.ctrl.invert |=> state_q.carrier == !$past(picked))
    else $error("carrier not inverted with polarity one");

  // Once the awaited falling edge is seen, the low carrier follows on the next edge.
  a_wait_release: assert property (
    (state_q.phase == phase_wait_fall && !mod_data && fall)
      |=> state_q.phase == phase_low)
    else $error("falling edge did not release the wait");

  // A write loads the other two control fields from the same word.
  a_flags_write: assert property (
    state_q.wr_ctrl |=>
      (state_q.ctrl.sync_en == $past(hwdata[CTRL_SYNC_BIT]) &&
       state_q.ctrl.invert == $past(hwdata[CTRL_INV_BIT])))
    else $error("sync or polarity not loaded from write data");

  // The status word mirrors the carrier and the phase seen at the address phase.
  a_status_read: assert property (
    (addr_phase && !hwrite && haddr == STATUS_OFFSET) |=>
      (hrdata[STAT_CARRIER_BIT] == $past(state_q.carrier) &&
       hrdata[STAT_WAIT_BIT] == ($past(state_q.phase) == phase_wait_fall)))
    else $error("status word does not show the phase");

  // Writes and unmapped reads leave zero on the read data lines.
  a_unmapped_zero: assert property (
    (addr_phase && (hwrite || (haddr != CTRL_OFFSET && haddr != STATUS_OFFSET)))
      |=> hrdata == 32'h0000_0000)
    else $error("unmapped or write access left read data");

  // The master takes read data a cycle after the address, so it must stand until then.
  a_rdata_hold: assert property (
    !addr_phase |=> $stable(hrdata))
    else $error("read data moved outside an address phase");

  c_wait_release: cover property (
    state_q.phase == phase_wait_fall ##1 state_q.phase == phase_low);

  c_reserved_sel: cover property (state_q.ctrl.sel[3] && state_q.ctrl.invert);

  // A master that never pipelines leaves two or three edges between these flags.
  c_write_then_read: cover property (state_q.wr_ctrl ##[2:3] state_q.rd_ctrl);

  c_sync_off_drop: cover property (
    (state_q.phase == phase_high && !state_q.ctrl.sync_en && !mod_data) ##1
      state_q.phase == phase_low);

  c_pin_route: cover property (state_q.ctrl.sel == SEL_PIN_TWO && state_q.carrier);

endmodule

`default_nettype wire

//--- inc/carrier_pkg.sv
// Shared constants and types for the high-carrier selector and its bus slave.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
`default_nettype none

package carrier_pkg;

  // Register byte offsets on the bus.
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  // Control word field positions.
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 4;
  localparam int CTRL_RSVD_BIT = 4;
  localparam int CTRL_SYNC_BIT = 5;
  localparam int CTRL_INV_BIT = 6;

  // Status word field positions.
  localparam int STAT_CARRIER_BIT = 0;
  localparam int STAT_HIGH_BIT = 1;
  localparam int STAT_WAIT_BIT = 2;

  // Source selector codes; codes 4'h8 and above are reserved.
  localparam logic [3:0] SEL_GROUND = 4'h0;
  localparam logic [3:0] SEL_PIN_ONE = 4'h1;
  localparam logic [3:0] SEL_PIN_TWO = 4'h2;
  localparam logic [3:0] SEL_REF_CLK = 4'h3;
  localparam logic [3:0] SEL_PWM_ONE = 4'h4;
  localparam logic [3:0] SEL_PWM_TWO = 4'h5;
  localparam logic [3:0] SEL_PWM_THREE = 4'h6;
  localparam logic [3:0] SEL_PWM_FOUR = 4'h7;

  // Number of carrier input pins.
  localparam int PIN_COUNT = 2;

  // Modulator phase with respect to the high carrier.
  typedef enum logic [1:0] {
    phase_low,
    phase_high,
    phase_wait_fall
  } phase_e;

  // Software-visible control fields.
  typedef struct packed {
    logic [3:0] sel;
    logic sync_en;
    logic invert;
  } ctrl_s;

  // Whole state of the selector module.
  typedef struct packed {
    ctrl_s ctrl;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [31:0] rdata;
    phase_e phase;
    logic carrier;
    logic carrier_prev;
  } sel_state_s;

  localparam ctrl_s CTRL_RESET = '{sel: 4'h0, sync_en: 1'b0, invert: 1'b0};
  localparam sel_state_s SEL_STATE_RESET = '{
    ctrl: CTRL_RESET,
    wr_ctrl: 1'b0,
    rd_ctrl: 1'b0,
    rdata: 32'h0000_0000,
    phase: phase_low,
    carrier: 1'b0,
    carrier_prev: 1'b0
  };

endpackage

`default_nettype wire

//--- inc/pin_sync_if.sv
// Bundle between the selector and its pin synchroniser.
// Assumes raw pins are asynchronous to hclk; synced values are on hclk.
`timescale 1ns/10ps
`default_nettype none

interface pin_sync_if;
  logic [1:0] raw;
  logic [1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

`default_nettype wire

//--- rtl/pin_sync.sv
// Two-stage synchroniser for the carrier input pins.
// Assumes the pins may change at any time relative to hclk.
`timescale 1ns/10ps
`default_nettype none

module pin_sync
  import carrier_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  pin_sync_if.sync_side pins
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] first;
    logic [PIN_COUNT-1:0] second;
  } sync_state_s;

  sync_state_s state_q;
  sync_state_s state_d;

  // The first stage feeds only the second, so metastability gets a full cycle.
  always_comb
  begin
    state_d = state_q;
    state_d.first = pins.raw;
    state_d.second = state_q.first;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign pins.synced = state_q.second;

endmodule

`default_nettype wire

//--- test/modulator_high_carrier_select_tb.sv
// Self-checking bench for the high-carrier selector and its AHB-Lite register slave.
// Assumes the selector is the only slave, so its hreadyout is fed back as hready.
`timescale 1ns/10ps
`default_nettype none

module modulator_high_carrier_select_tb
  import carrier_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic mod_data = 1'b0;
  logic [7:0] srcv = 8'h00; // Bit n is the source that selector code n routes.
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic high_carrier;
  logic high_carrier_active;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [7:0] pat;
  logic [31:0] expc;

  // The clock toggles every half period of 2 ns.
  always #2 hclk = ~hclk;

  high_carrier_select i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .mod_data(mod_data),
    .capture_pwm_unit_one(srcv[4]),
    .capture_pwm_unit_two(srcv[5]),
    .capture_pwm_unit_three(srcv[6]),
    .capture_pwm_unit_four(srcv[7]),
    .reference_clock_output(srcv[3]),
    .carrier_input_pin_one(srcv[1]),
    .carrier_input_pin_two(srcv[2]),
    .high_carrier(high_carrier),
    .high_carrier_active(high_carrier_active)
  );

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single-word transfer; waits on hready rather than assuming zero wait states.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // A hang is cut short well above the few hundred cycles the tests need.
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  // Main sequence: reset state, control field access, routing, then the switch timing.
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_reset", rd, 32'h0000_0000);
    chk("carrier_reset", {31'h0, high_carrier}, 32'h0);
    chk("ready_reset", {31'h0, hreadyout}, 32'h1);
    bus(1'b0, 32'h0000_0008, 32'h0, rd);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1'b1, CTRL_OFFSET, 32'hffff_ffff, rd);
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_rw", rd, 32'h0000_006f);
    // Codes one to seven see their own source alone high, then alone low, so a wrong route shows; the rest see all high, then all low.
    for (int inv = 0; inv < 2; inv++)
      for (int s = 0; s < 16; s++)
      begin
        bus(1'b1, CTRL_OFFSET, 32'(inv * 64 + s), rd);
        for (int k = 0; k < 2; k++)
        begin
          pat = (s > 0 && s < 8) ? 8'(1 << s) : 8'hfe;
          if (k == 1)
            pat = ~pat & 8'hfe;
          @(posedge hclk);
          srcv <= pat;
          repeat (5) @(posedge hclk);
          @(negedge hclk);
          expc = {31'h0, ((s > 0 && s < 8) ? pat[s] : 1'b0) ^ inv[0]};
          chk("carrier_route", {31'h0, high_carrier}, expc);
        end
      end
    // With sync on, the high phase outlasts the data drop until the carrier falls.
    bus(1'b1, CTRL_OFFSET, 32'h0000_0024, rd);
    @(posedge hclk);
    srcv <= 8'h10;
    mod_data <= 1'b1;
    repeat (3) @(posedge hclk);
    mod_data <= 1'b0;
    repeat (6) @(posedge hclk);
    @(negedge hclk);
    chk("held_high", {31'h0, high_carrier_active}, 32'h1);
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    chk("status_wait", rd, 32'h0000_0007);
    @(posedge hclk);
    srcv <= 8'h00;
    repeat (4) @(posedge hclk);
    @(negedge hclk);
    chk("released", {31'h0, high_carrier_active}, 32'h0);
    // With sync off, the switch happens while the carrier is still high.
    bus(1'b1, CTRL_OFFSET, 32'h0000_0004, rd);
    @(posedge hclk);
    srcv <= 8'h10;
    mod_data <= 1'b1;
    repeat (3) @(posedge hclk);
    mod_data <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("unsynced_switch", {31'h0, high_carrier_active}, 32'h0);
    chk("carrier_still_high", {31'h0, high_carrier}, 32'h1);
    end_of_test();
  end
endmodule

`default_nettype wire
